// ===== qsp_pkg.sv
// constants and types shared by the queued spi master
package qsp_pkg;
   // command half of a queue word (bit positions in the 32-bit word)
   localparam int QSP_CMD_CONT_BIT = 31;
   localparam int QSP_CMD_ATTR_LSB = 28;
   localparam int QSP_CMD_ATTR_W = 3;
   localparam int QSP_CMD_EOQ_BIT = 27;
   localparam int QSP_CMD_CTC_BIT = 26;
   localparam int QSP_CMD_CS_LSB = 16;
   // field widths
   localparam int QSP_WORD_W = 32;
   localparam int QSP_DATA_W = 16;
   localparam int QSP_PRE_W = 2;
   localparam int QSP_SCL_W = 4;
   localparam int QSP_BAUD_W = 4;
   localparam int QSP_DLY_W = 19;
   localparam int QSP_TCNT_W = 16;
   localparam int QSP_BIT_W = 4;
   // reset values
   localparam logic [QSP_TCNT_W-1:0] QSP_TCNT_RST = 16'h0000;
   localparam logic [QSP_DATA_W-1:0] QSP_DATA_RST = 16'h0000;

   // one transfer-attribute set
   typedef struct packed {
      logic [QSP_BAUD_W-1:0] baud;
      logic [QSP_PRE_W-1:0] cs_to_clock_prescale;
      logic [QSP_SCL_W-1:0] cs_to_clock_scale;
      logic [QSP_PRE_W-1:0] after_clock_prescale;
      logic [QSP_SCL_W-1:0] after_clock_scale;
      logic [QSP_PRE_W-1:0] after_transfer_prescale;
      logic [QSP_SCL_W-1:0] after_transfer_scale;
   } qsp_attr_t;

   // frame sequencer states
   typedef enum logic [2:0] {
      QSP_IDLE,
      QSP_LEAD,
      QSP_SHIFT_LO,
      QSP_SHIFT_HI,
      QSP_TRAIL,
      QSP_GAP
   } qsp_state_t;
endpackage

// ===== qsp_master.sv
// queued spi master: command queue, attribute sets, shifter, rx queue
`timescale 1ns/1ps
// Overview of operation
// - separate flush requests empty the transmit queue, receive queue or both.
// - every chip-select line has its own idle level input.
// - each attribute set holds lead, trail and gap delays.
// - each delay prescaler is two bits, codes zero to three.
// - each delay scaler is four bits, codes zero to fifteen.
// - several attribute sets, each written alone through a select.
// - queue word is command in upper half, data in lower half.
// - command picks continuous cs, attribute set, cs line, eoq, count clear.
// - frames start only while disable and halt are both low.
// - received word is queued when its frame completes, unless the rx queue is full.
// - status flags clear only on a one written to them.
// - transmit and receive queues each have their own enable.
// - master or slave mode; slave keeps only sixteen data bits.
module qsp_master
   import qsp_pkg::*;
#(
   parameter int NCS = 6,
   parameter int NATTR = 2,
   parameter int TXD = 4,
   parameter int RXD = 4
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // module configuration
   input wire logic module_disable_bit_in,
   input wire logic halt_in,
   input wire logic master_mode_in,
   input wire logic tx_fifo_en_in,
   input wire logic rx_fifo_en_in,
   input wire logic flush_tx_in,
   input wire logic flush_rx_in,
   input wire logic [NCS-1:0] cs_idle_level_in,
   // attribute set programming
   input wire logic attr_wr_in,
   input wire logic [QSP_CMD_ATTR_W-1:0] attr_sel_in,
   input wire logic [QSP_BAUD_W-1:0] attr_baud_in,
   input wire logic [QSP_PRE_W-1:0] cs_to_clock_prescale_in,
   input wire logic [QSP_SCL_W-1:0] cs_to_clock_scale_in,
   input wire logic [QSP_PRE_W-1:0] after_clock_prescale_in,
   input wire logic [QSP_SCL_W-1:0] after_clock_scale_in,
   input wire logic [QSP_PRE_W-1:0] after_transfer_prescale_in,
   input wire logic [QSP_SCL_W-1:0] after_transfer_scale_in,
   // transmit queue push
   input wire logic push_valid_in,
   input wire logic [QSP_WORD_W-1:0] transmit_push_word_in,
   output logic push_ready_out,
   // receive queue pop
   input wire logic pop_in,
   output logic rx_valid_out,
   output logic [QSP_DATA_W-1:0] receive_pop_word_out,
   // status
   input wire logic clear_tx_complete_in,
   input wire logic clear_eoq_in,
   output logic tx_complete_out,
   output logic eoq_out,
   output logic busy_out,
   output logic [QSP_TCNT_W-1:0] transfer_count_out,
   // serial side
   output logic sck_out,
   output logic mosi_out,
   input wire logic miso_in,
   output logic [NCS-1:0] cs_out
);
   localparam int TPW = $clog2(TXD);
   localparam int RPW = $clog2(RXD);

   typedef struct packed {
      qsp_state_t st;
      logic [TXD-1:0][QSP_WORD_W-1:0] tx_mem;
      logic [TPW:0] tx_wp;
      logic [TPW:0] tx_rp;
      logic [RXD-1:0][QSP_DATA_W-1:0] rx_mem;
      logic [RPW:0] rx_wp;
      logic [RPW:0] rx_rp;
      logic [NATTR-1:0][$bits(qsp_attr_t)-1:0] attr;
      logic [QSP_DATA_W-1:0] cmd;
      logic [QSP_DATA_W-1:0] shreg;
      logic [QSP_DATA_W-1:0] rxsh;
      logic [QSP_BIT_W-1:0] bitn;
      logic [QSP_DLY_W-1:0] cnt;
      logic sck;
      logic [NCS-1:0] cs_act;
      logic tc_flag;
      logic eoq_flag;
      logic [QSP_TCNT_W-1:0] tcnt;
      logic miso_s1;
      logic miso_s2;
   } qsp_regs_t;

   qsp_regs_t s;
   qsp_regs_t next_s;

   // delay in cycles: prescale 1,3,5,7 times scale 2,4,...,65536
   function automatic logic [QSP_DLY_W-1:0] dly(
      input logic [QSP_PRE_W-1:0] pre,
      input logic [QSP_SCL_W-1:0] sc);
      logic [QSP_DLY_W-1:0] m;
      m = {{(QSP_DLY_W-QSP_PRE_W-1){1'b0}}, pre, 1'b1};
      return m << ({1'b0, sc} + 5'h01);
   endfunction

   // attribute set named by a command, set 0 when out of range
   function automatic qsp_attr_t pick(
      input logic [NATTR-1:0][$bits(qsp_attr_t)-1:0] a,
      input logic [QSP_DATA_W-1:0] c);
      logic [QSP_CMD_ATTR_W-1:0] i;
      i = c[QSP_CMD_ATTR_LSB-QSP_DATA_W +: QSP_CMD_ATTR_W];
      if (int'(i) < NATTR) begin
         return qsp_attr_t'(a[i]);
      end
      return qsp_attr_t'(a[0]);
   endfunction

   logic [TPW:0] tx_cnt;
   logic [TPW:0] tx_cap;
   logic [RPW:0] rx_cnt;
   logic [RPW:0] rx_cap;
   logic run;

   // queue levels and capacities
   always_comb begin
      tx_cnt = s.tx_wp - s.tx_rp;
      rx_cnt = s.rx_wp - s.rx_rp;
      tx_cap = tx_fifo_en_in ? (TPW+1)'(TXD) : (TPW+1)'(1);
      rx_cap = rx_fifo_en_in ? (RPW+1)'(RXD) : (RPW+1)'(1);
      run = !module_disable_bit_in && !halt_in && master_mode_in;
   end

   // next-state logic
   always_comb begin
      logic [QSP_WORD_W-1:0] w;
      qsp_attr_t a;
      qsp_attr_t na;
      w = s.tx_mem[s.tx_rp[TPW-1:0]];
      a = pick(s.attr, s.cmd);
      na = pick(s.attr, w[QSP_WORD_W-1:QSP_DATA_W]);
      next_s = s;
      // miso synchroniser
      next_s.miso_s1 = miso_in;
      next_s.miso_s2 = s.miso_s1;
      // queue push; slave mode keeps only the data half
      if (push_valid_in && push_ready_out) begin
         next_s.tx_mem[s.tx_wp[TPW-1:0]] = master_mode_in ?
            transmit_push_word_in :
            {QSP_DATA_RST, transmit_push_word_in[QSP_DATA_W-1:0]};
         next_s.tx_wp = s.tx_wp + 1'b1;
      end
      // attribute set write
      if (attr_wr_in && int'(attr_sel_in) < NATTR) begin
         next_s.attr[attr_sel_in] = {attr_baud_in,
            cs_to_clock_prescale_in, cs_to_clock_scale_in,
            after_clock_prescale_in, after_clock_scale_in,
            after_transfer_prescale_in, after_transfer_scale_in};
      end
      // receive pop
      if (pop_in && rx_cnt != '0) begin
         next_s.rx_rp = s.rx_rp + 1'b1;
      end
      // write-one-to-clear, later set wins
      if (clear_tx_complete_in) begin
         next_s.tc_flag = 1'b0;
      end
      if (clear_eoq_in) begin
         next_s.eoq_flag = 1'b0;
      end
      // frame sequencer
      case (s.st)
         QSP_IDLE: begin
            next_s.sck = 1'b0;
            if (run && tx_cnt != '0) begin
               next_s.tx_rp = s.tx_rp + 1'b1;
               next_s.cmd = w[QSP_WORD_W-1:QSP_DATA_W];
               next_s.shreg = w[QSP_DATA_W-1:0];
               next_s.bitn = '0;
               if (s.cs_act != '0 &&
                   s.cs_act == w[QSP_CMD_CS_LSB +: NCS]) begin
                  next_s.cnt = QSP_DLY_W'(na.baud);
                  next_s.st = QSP_SHIFT_LO;
               end else begin
                  next_s.cs_act = w[QSP_CMD_CS_LSB +: NCS];
                  next_s.cnt = dly(na.cs_to_clock_prescale,
                     na.cs_to_clock_scale) - 1'b1;
                  next_s.st = QSP_LEAD;
               end
            end
         end
         QSP_LEAD: begin
            if (s.cnt == '0) begin
               next_s.cnt = QSP_DLY_W'(a.baud);
               next_s.st = QSP_SHIFT_LO;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         QSP_SHIFT_LO: begin
            if (s.cnt == '0) begin
               next_s.sck = 1'b1;
               next_s.rxsh = {s.rxsh[QSP_DATA_W-2:0], s.miso_s2};
               next_s.cnt = QSP_DLY_W'(a.baud);
               next_s.st = QSP_SHIFT_HI;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         QSP_SHIFT_HI: begin
            if (s.cnt == '0) begin
               next_s.sck = 1'b0;
               if (s.bitn == QSP_BIT_W'(QSP_DATA_W - 1)) begin
                  // frame done: queue rx word, drop it when full
                  if (rx_cnt < rx_cap) begin
                     next_s.rx_mem[s.rx_wp[RPW-1:0]] = s.rxsh;
                     next_s.rx_wp = s.rx_wp + 1'b1;
                  end
                  next_s.tc_flag = 1'b1;
                  if (s.cmd[QSP_CMD_EOQ_BIT-QSP_DATA_W]) begin
                     next_s.eoq_flag = 1'b1;
                  end
                  next_s.tcnt = s.cmd[QSP_CMD_CTC_BIT-QSP_DATA_W] ?
                     16'h0001 : s.tcnt + 1'b1;
                  if (s.cmd[QSP_CMD_CONT_BIT-QSP_DATA_W]) begin
                     next_s.cnt = dly(a.after_transfer_prescale,
                        a.after_transfer_scale) - 1'b1;
                     next_s.st = QSP_GAP;
                  end else begin
                     next_s.cnt = dly(a.after_clock_prescale,
                        a.after_clock_scale) - 1'b1;
                     next_s.st = QSP_TRAIL;
                  end
               end else begin
                  next_s.bitn = s.bitn + 1'b1;
                  next_s.shreg = {s.shreg[QSP_DATA_W-2:0], 1'b0};
                  next_s.cnt = QSP_DLY_W'(a.baud);
                  next_s.st = QSP_SHIFT_LO;
               end
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         QSP_TRAIL: begin
            if (s.cnt == '0) begin
               next_s.cs_act = '0;
               next_s.cnt = dly(a.after_transfer_prescale,
                  a.after_transfer_scale) - 1'b1;
               next_s.st = QSP_GAP;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         QSP_GAP: begin
            if (s.cnt == '0) begin
               next_s.st = QSP_IDLE;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         default: begin
            next_s.st = QSP_IDLE;
         end
      endcase
      // flushes override pushes and pops of the same cycle
      if (flush_tx_in) begin
         next_s.tx_wp = s.tx_wp;
         next_s.tx_rp = s.tx_wp;
      end
      if (flush_rx_in) begin
         next_s.rx_rp = next_s.rx_wp;
      end
   end

   // state register
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign push_ready_out = tx_cnt < tx_cap;
   assign rx_valid_out = rx_cnt != '0;
   assign receive_pop_word_out = s.rx_mem[s.rx_rp[RPW-1:0]];
   assign tx_complete_out = s.tc_flag;
   assign eoq_out = s.eoq_flag;
   assign busy_out = s.st != QSP_IDLE;
   assign transfer_count_out = s.tcnt;
   assign sck_out = s.sck;
   assign mosi_out = s.shreg[QSP_DATA_W-1];
   assign cs_out = s.cs_act ^ cs_idle_level_in;
endmodule

// ===== qsp_master_checker.sv
// port assertions for the queued spi master
`timescale 1ns/1ps
module qsp_master_checker #(
   parameter int NCS = 6
) (
   // clock, reset and controls
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic module_disable_bit_in,
   input wire logic halt_in,
   input wire logic master_mode_in,
   input wire logic clear_eoq_in,
   input wire logic clear_tx_complete_in,
   input wire logic [NCS-1:0] cs_idle_level_in,
   // observed outputs
   input wire logic tx_complete_out,
   input wire logic eoq_out,
   input wire logic busy_out,
   input wire logic rx_valid_out,
   input wire logic sck_out,
   input wire logic [NCS-1:0] cs_out,
   input wire logic [15:0] transfer_count_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   // lines idle straight after reset
   chk_reset_idle: assert property (
      $fell(sys_rst_in) |-> cs_out == cs_idle_level_in && !sck_out && !eoq_out)
      else $error("lines not idle after reset");
   // no frame starts while blocked
   chk_halt_blocks: assert property (
      !busy_out && (halt_in || module_disable_bit_in || !master_mode_in)
      |=> !busy_out) else $error("frame started while blocked");
   // clock only inside a frame with a line selected
   chk_sck_framed: assert property (
      sck_out |-> busy_out && cs_out != cs_idle_level_in)
      else $error("clock outside a selected frame");
   chk_eoq_sticky: assert property (
      eoq_out && !clear_eoq_in |=> eoq_out) else $error("eoq lost");
   chk_eoq_clear: assert property (
      eoq_out && clear_eoq_in && !busy_out |=> !eoq_out)
      else $error("eoq not cleared");
   chk_done_sticky: assert property (
      tx_complete_out && !clear_tx_complete_in |=> tx_complete_out)
      else $error("done flag lost");
   // completion, received word and count all land on the last fall
   chk_done_edge: assert property (
      $rose(tx_complete_out) |-> $fell(sck_out)) else $error("done off edge");
   chk_rx_edge: assert property (
      $rose(rx_valid_out) |-> $fell(sck_out)) else $error("rx word off edge");
   chk_count_step: assert property (
      $changed(transfer_count_out) |-> $fell(sck_out) &&
      (transfer_count_out == 16'h0001 ||
       transfer_count_out == $past(transfer_count_out) + 16'h0001))
      else $error("count step wrong");
endmodule

// ===== qsp_slave_model.sv
// spi slave that answers every frame with a given word
`timescale 1ns/1ps
module qsp_slave_model (
   // serial side
   input wire logic sck_in,
   input wire logic sel_in,
   input wire logic mosi_in,
   output logic miso_out,
   // bench side
   input wire logic [15:0] reply_in,
   output logic [15:0] got_out
);
   logic [15:0] sh = 16'h0000;
   int nbit = 0;
   // load the answer as the line is selected
   always @(posedge sel_in) begin
      sh = reply_in;
      nbit = 0;
   end
   // capture on rise, msb first
   always @(posedge sck_in) begin
      got_out = {got_out[14:0], mosi_in};
      nbit++;
   end
   // next bit on fall, fresh answer after sixteen
   always @(negedge sck_in) begin
      sh = (nbit % 16 == 0) ? reply_in : sh << 1;
   end
   // released line shows the inverse of the top bit of sh, the next answer's msb once sixteen bits are done
   assign miso_out = sel_in ? sh[15] : ~sh[15];
endmodule

// ===== tb_queued_spi_master_command_port.sv
// bench for the queued spi master
`timescale 1ns/1ps
module tb_queued_spi_master_command_port;
   // design ports and bench state
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic module_disable_bit_in, halt_in, master_mode_in, tx_fifo_en_in;
   logic rx_fifo_en_in, flush_tx_in, flush_rx_in, attr_wr_in;
   logic push_valid_in, pop_in, clear_tx_complete_in, clear_eoq_in;
   logic miso_in, push_ready_out, rx_valid_out, tx_complete_out;
   logic eoq_out, busy_out, sck_out, mosi_out, sel, ok, held;
   logic [5:0] cs_idle_level_in, cs_out;
   logic [2:0] attr_sel_in;
   logic [3:0] attr_baud_in, cs_to_clock_scale_in, after_clock_scale_in;
   logic [3:0] after_transfer_scale_in;
   logic [1:0] cs_to_clock_prescale_in, after_clock_prescale_in;
   logic [1:0] after_transfer_prescale_in;
   logic [31:0] transmit_push_word_in, rnd = 32'h20b1;
   logic [15:0] receive_pop_word_out, transfer_count_out, got, reply, d;
   logic [15:0] rxq[$];
   int errors = 0, num_checks = 0, hi, lead, tcnt, i, k, n;
   qsp_master u_dut (.*);
   qsp_slave_model u_slave (.sck_in(sck_out), .sel_in(sel),
      .mosi_in(mosi_out), .miso_out(miso_in), .reply_in(reply),
      .got_out(got));
   assign sel = |(cs_out ^ cs_idle_level_in);
   initial forever #50 ref_clk_in = ~ref_clk_in;
   // high and lead cycles of the current frame
   always @(posedge ref_clk_in) begin
      if (sck_out) hi++;
      else if (sel && hi == 0) lead++;
   end
   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one set: baud and the same delay code for all three delays
   task automatic setattr(input int s, b, p, c);
      @(negedge ref_clk_in);
      {attr_wr_in, attr_sel_in, attr_baud_in} = {1'b1, 3'(s), 4'(b)};
      {cs_to_clock_prescale_in, after_clock_prescale_in} = {2{2'(p)}};
      after_transfer_prescale_in = 2'(p);
      {cs_to_clock_scale_in, after_clock_scale_in} = {2{4'(c)}};
      after_transfer_scale_in = 4'(c);
      @(negedge ref_clk_in);
      attr_wr_in = 1'b0;
   endtask
   // offer one word for one edge, ready seen before it
   task automatic push(input logic [31:0] w, output logic acc);
      @(negedge ref_clk_in);
      acc = push_ready_out;
      {push_valid_in, transmit_push_word_in} = {1'b1, w};
      @(negedge ref_clk_in);
      push_valid_in = 1'b0;
   endtask
   task automatic idle_wait();
      repeat (2) @(negedge ref_clk_in);
      for (n = 0; n < 5000 && busy_out !== 1'b0; n++) @(negedge ref_clk_in);
      if (n == 5000) begin
         errors++;
         conclude();
      end
   endtask
   // one frame on line ln with set s, then pop, flush or keep the rx word
   task automatic frame(input int ln, s, cont, eq, ctc, fl);
      d = 16'(xs());
      held = (cs_out !== cs_idle_level_in);
      if (!held) reply = 16'(xs());
      if (rxq.size() < (rx_fifo_en_in ? 4 : 1)) rxq.push_back(reply);
      hi = 0;
      lead = 0;
      push({1'(cont), 3'(s), 1'(eq), 1'(ctc), 4'h0, 6'(1 << ln), d}, ok);
      idle_wait();
      tcnt = ctc ? 1 : tcnt + 1;
      check("tx data", got, d);
      check("rx data", receive_pop_word_out, rxq[0]);
      check("count", transfer_count_out, tcnt);
      check("high time", hi, 16 * (4 - s));
      if (!held) check("lead", lead, s ? 15 : 6);
      check("flags", {eoq_out, tx_complete_out}, {1'(eq), 1'b1});
      check("cs", cs_out ^ cs_idle_level_in, cont ? 1 << ln : 0);
      // fl: 0 pops the word, 1 flushes the rx queue, 2 leaves it queued
      if (fl == 1) rxq.delete();
      else if (fl == 0) void'(rxq.pop_front());
      {pop_in, flush_rx_in} = {1'(fl == 0), 1'(fl == 1)};
      {clear_tx_complete_in, clear_eoq_in} = 2'b11;
      @(negedge ref_clk_in);
      {pop_in, flush_rx_in, clear_tx_complete_in, clear_eoq_in} = 4'h0;
      @(negedge ref_clk_in);
      check("rx left", rx_valid_out, rxq.size() != 0);
      check("cleared", {eoq_out, tx_complete_out}, 0);
   endtask
   initial begin
      {module_disable_bit_in, halt_in, flush_tx_in, flush_rx_in} = 4'h0;
      {attr_wr_in, push_valid_in, pop_in, clear_tx_complete_in} = 4'h0;
      {master_mode_in, tx_fifo_en_in, rx_fifo_en_in, clear_eoq_in} = 4'he;
      {attr_sel_in, attr_baud_in, transmit_push_word_in} = 39'h0;
      {cs_to_clock_prescale_in, after_clock_prescale_in} = 4'h0;
      {after_transfer_prescale_in, after_transfer_scale_in} = 6'h00;
      {cs_to_clock_scale_in, after_clock_scale_in} = 8'h00;
      {cs_idle_level_in, reply} = {6'(xs()), 16'h0000};
      repeat (16) @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      check("idle cs", cs_out, cs_idle_level_in);
      setattr(0, 3, 0, 0);
      setattr(1, 2, 1, 1);
      // rx queue drops to depth one for the last frame, which is lost
      for (i = 0; i < 7; i++) begin
         rx_fifo_en_in = (i != 6);
         frame(i - (i > 2), i % 2, i == 2, i == 3 || i == 6, i % 4 == 0,
            i == 4 ? 1 : 2 * (i == 5));
      end
      // blocked modes queue words but never start a frame
      for (k = 0; k < 3; k++) begin
         {module_disable_bit_in, halt_in} = {k == 0, k == 1};
         master_mode_in = (k != 2);
         tx_fifo_en_in = (k == 0);
         for (i = 0; i < 5; i++) begin
            push(xs(), ok);
            check("accepted", ok, i < (k == 0 ? 4 : 1));
         end
         repeat (40) @(negedge ref_clk_in);
         check("stalled", busy_out, 0);
         flush_tx_in = 1'b1;
         @(negedge ref_clk_in);
         {flush_tx_in, module_disable_bit_in, halt_in, master_mode_in} = 4'h1;
         repeat (20) @(negedge ref_clk_in);
         check("flushed", {busy_out, push_ready_out}, 1);
      end
      conclude();
   end
endmodule
bind qsp_master qsp_master_checker #(.NCS(NCS)) u_chk (.*);
